// [tmr_pkg.sv]
package tmr_pkg;

  // register data width and bus address width
  localparam int DATA_W = 8;
  localparam int ADR_W  = 10;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RELOAD = 8'hCD;
  localparam logic [7:0] IDX_MODE   = 8'hDA;
  localparam logic [7:0] IDX_COUNT  = 8'hDB;
  localparam logic [7:0] IDX_STATUS = 8'hDC;

  // timer_mode_control field positions
  localparam int MODE_PWM_BIT   = 0;
  localparam int MODE_TOUT_BIT  = 1;
  localparam int MODE_ALOAD_BIT = 2;
  localparam int MODE_CKS_BIT   = 3;
  localparam int MODE_RATE_LSB  = 4;
  localparam int MODE_RATE_W    = 3;
  localparam int MODE_EN_BIT    = 7;

  // timer_status_control field positions
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_IEN_BIT = 1;
  localparam int STAT_PIN_BIT = 2;

  // reset values
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // overflow boundary masks: N-1 for N = 256, 64, 32, 16
  localparam logic [7:0] BOUND_256 = 8'hFF;
  localparam logic [7:0] BOUND_64  = 8'h3F;
  localparam logic [7:0] BOUND_32  = 8'h1F;
  localparam logic [7:0] BOUND_16  = 8'h0F;

  // interrupt vector address taken by the processor on overflow
  localparam logic [7:0] IRQ_VECTOR = 8'h08;

  // bus answer timing in clock cycles after the request is seen
  localparam int WB_ACK_CYCLES = 1;

  // bus answer state
  typedef enum logic {
    TMR_BUS_IDLE = 1'b0,
    TMR_BUS_ACK  = 1'b1
  } tmr_bus_state_t;

endpackage

// [tmr_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int RATE_W = MODE_RATE_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // control
  input  wire logic              run,
  input  wire logic [RATE_W-1:0] rate,
  // one-cycle tick at the divided rate
  output logic                   tick
);

  logic [7:0] div_cnt;
  logic [7:0] div_mask;
  logic       next_tick;

  // code 0 divides by 256, code 7 by 2
  assign div_mask  = 8'hFF >> rate;
  assign next_tick = run && ((div_cnt & div_mask) == div_mask);

  // free divider, held at zero while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      tick    <= 1'b0;
    end else begin
      div_cnt <= run ? div_cnt + 8'h01 : 8'h00;
      tick    <= next_tick;
    end
  end

endmodule
`default_nettype wire

// [tmr_timer.sv]
// Functional notes
// - counter holds while count_enable is 0, advances while it is 1.
// - counter steps by one for each period of the selected clock.
// - a step from the boundary value back to zero is an overflow.
// - overflow sets overflow_flag, which stays until software clears it.
// - enabled overflow requests the interrupt at vector address 8.
// - reload writes go to a buffer, copied into the counter at overflow; in PWM the counter restarts at zero and the buffer becomes the duty.
// - reload follows auto_reload_enable, forced on in PWM mode.
// - counting, flag and PWM keep running in green mode, never waking.
// - source is prescaled instruction clock, or event pin when selected.
// - prescale codes 000 to 111 divide by 256 down to 2.
// - external event clocking suppresses and clears the pin interrupt flag.
// - pwm_output_enable puts the PWM wave on the output pin.
// - toggle_output_enable puts the overflow toggle on the pin while PWM is off.
// - auto_reload_enable controls reload only while PWM is off.
// - boundary 256, or 256/64/32/16 by reload and toggle bits in PWM on the instruction clock.
// - PWM starts high, goes low at compare match, high at overflow.
// - toggle output inverts at every overflow.
// - event counter advances on each falling edge of the event pin.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic             I_CLK,
  input  wire logic             I_RESET_N,
  // wishbone classic slave
  input  wire logic             I_WB_CYC,
  input  wire logic             I_WB_STB,
  input  wire logic             I_WB_WE,
  input  wire logic [ADR_W-1:0] I_WB_ADR,
  input  wire logic [3:0]       I_WB_SEL,
  input  wire logic [31:0]      I_WB_DAT,
  output logic      [31:0]      O_WB_DAT,
  output logic                  O_WB_ACK,
  // event input pin
  input  wire logic             I_EVENT_PIN,
  // general purpose drive of the shared output pin
  input  wire logic             I_GPIO_OUT,
  input  wire logic             I_GPIO_OE,
  // shared output pin
  output logic                  O_WAVE_OUT,
  output logic                  O_WAVE_OE,
  // system side
  output logic                  O_OVF_IRQ,
  output logic      [7:0]       O_IRQ_VECTOR,
  output logic                  O_PIN_IRQ_FLAG,
  output logic                  O_WAKEUP
);

  // overflow boundary mask, shared by overflow and compare logic
  function automatic logic [7:0] bound_mask(input logic pwm, input logic cks,
                                            input logic aload, input logic tout);
    logic [1:0] sel;
    sel = {aload, tout};
    if (!pwm || cks) begin
      bound_mask = BOUND_256;
    end else begin
      case (sel)
        2'b00:   bound_mask = BOUND_256;
        2'b01:   bound_mask = BOUND_64;
        2'b10:   bound_mask = BOUND_32;
        default: bound_mask = BOUND_16;
      endcase
    end
  endfunction

  // reset synchroniser
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // registers
  logic [7:0]     mode_control;
  logic [7:0]     count_value;
  logic [7:0]     reload_buffer;
  logic [7:0]     reload_value;
  logic           overflow_flag;
  logic           overflow_irq_enable;
  logic           pin_irq_flag;
  logic           pwm_level;
  logic           toggle_level;
  tmr_bus_state_t bus_state;

  // mode fields
  logic                   count_enable;
  logic [MODE_RATE_W-1:0] prescale_select;
  logic                   clock_source_select;
  logic                   auto_reload_enable;
  logic                   toggle_output_enable;
  logic                   pwm_output_enable;

  assign count_enable         = mode_control[MODE_EN_BIT];
  assign prescale_select      = mode_control[MODE_RATE_LSB +: MODE_RATE_W];
  assign clock_source_select  = mode_control[MODE_CKS_BIT];
  assign auto_reload_enable   = mode_control[MODE_ALOAD_BIT];
  assign toggle_output_enable = mode_control[MODE_TOUT_BIT];
  assign pwm_output_enable    = mode_control[MODE_PWM_BIT];

  // event pin synchroniser and falling edge detector
  logic event_meta;
  logic event_sync;
  logic event_prev;
  logic event_fall;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      event_meta <= 1'b1;
      event_sync <= 1'b1;
      event_prev <= 1'b1;
    end else begin
      event_meta <= I_EVENT_PIN;
      event_sync <= event_meta;
      event_prev <= event_sync;
    end
  end

  assign event_fall = event_prev && !event_sync;

  // instruction clock prescaler
  logic pre_tick;

  tmr_prescaler #(
    .RATE_W (MODE_RATE_W)
  ) u_prescaler (
    .clk   (I_CLK),
    .rst_n (rst_n),
    .run   (count_enable && !clock_source_select),
    .rate  (prescale_select),
    .tick  (pre_tick)
  );

  // bus decode
  logic [7:0] wb_index;
  logic       wb_req;
  logic       wb_wr;
  logic       wr_mode;
  logic       wr_count;
  logic       wr_reload;
  logic       wr_status;
  logic [7:0] wr_data;

  assign wb_index  = I_WB_ADR[9:2];
  assign wb_req    = I_WB_CYC && I_WB_STB && (bus_state == TMR_BUS_IDLE);
  assign wb_wr     = wb_req && I_WB_WE && I_WB_SEL[0];
  assign wr_data   = I_WB_DAT[7:0];
  assign wr_mode   = wb_wr && (wb_index == IDX_MODE);
  assign wr_count  = wb_wr && (wb_index == IDX_COUNT);
  assign wr_reload = wb_wr && (wb_index == IDX_RELOAD);
  assign wr_status = wb_wr && (wb_index == IDX_STATUS);

  // counting
  logic [7:0] bound;
  logic       step;
  logic       at_bound;
  logic       overflow;
  logic       reload_on;
  logic [7:0] next_count;

  assign bound = bound_mask(pwm_output_enable, clock_source_select,
                            auto_reload_enable, toggle_output_enable);
  assign step  = count_enable &&
                 (clock_source_select ? event_fall : pre_tick);
  assign at_bound  = ((count_value & bound) == bound);
  assign overflow  = step && at_bound;
  assign reload_on = pwm_output_enable ? count_enable : auto_reload_enable;

  // in PWM the counter restarts at zero and the reload value is the duty
  always_comb begin
    if (wr_count) begin
      next_count = wr_data;
    end else if (overflow) begin
      if (pwm_output_enable) begin
        next_count = 8'h00;
      end else if (reload_on) begin
        next_count = reload_buffer;
      end else begin
        next_count = 8'h00;
      end
    end else if (step) begin
      next_count = (count_value + 8'h01) & bound;
    end else begin
      next_count = count_value;
    end
  end

  // status flags: a hardware set wins over a software clear
  logic next_ovf_flag;
  logic next_ien;
  logic next_pin_flag;
  logic pin_set;

  assign pin_set       = event_fall && !clock_source_select;
  assign next_ovf_flag = overflow ||
                         (overflow_flag && !(wr_status && !wr_data[STAT_OVF_BIT]));
  assign next_ien      = wr_status ? wr_data[STAT_IEN_BIT] : overflow_irq_enable;
  assign next_pin_flag = !clock_source_select &&
                         (pin_set ||
                          (pin_irq_flag && !(wr_status && !wr_data[STAT_PIN_BIT])));

  // waveform generation
  logic next_pwm;
  logic next_toggle;
  logic duty_match;


  // match on the value the counter takes at this edge, so the pin falls as the count
  // reaches the duty rather than one clock later
  assign duty_match  = ((next_count & bound) == (reload_value & bound));

  assign next_pwm    = (!count_enable || overflow) ? 1'b1 :
                       (duty_match ? 1'b0 : pwm_level);
  assign next_toggle = overflow ? !toggle_level : toggle_level;

  // shared pin selection
  logic next_pin_out;
  logic next_pin_oe;

  assign next_pin_out = pwm_output_enable    ? next_pwm :
                        toggle_output_enable ? next_toggle : I_GPIO_OUT;
  assign next_pin_oe  = (pwm_output_enable || toggle_output_enable) ? 1'b1 : I_GPIO_OE;

  // read mux
  logic [7:0] rd_data;

  assign rd_data = (wb_index == IDX_MODE)   ? mode_control :
                   (wb_index == IDX_COUNT)  ? count_value :
                   (wb_index == IDX_STATUS) ?
                     {5'h00, pin_irq_flag, overflow_irq_enable, overflow_flag} :
                   8'h00;

  // mode register
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_control <= MODE_RST;
    end else if (wr_mode) begin
      mode_control <= wr_data;
    end
  end

  // counter and double buffered reload
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      count_value   <= COUNT_RST;
      reload_buffer <= RELOAD_RST;
      reload_value  <= RELOAD_RST;
    end else begin
      count_value <= next_count;
      if (wr_reload) begin
        reload_buffer <= wr_data;
      end
      if (overflow && reload_on) begin
        reload_value <= reload_buffer;
      end else if (!count_enable) begin
        reload_value <= reload_buffer;
      end
    end
  end

  // flags and enables
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag       <= STATUS_RST[STAT_OVF_BIT];
      overflow_irq_enable <= STATUS_RST[STAT_IEN_BIT];
      pin_irq_flag        <= STATUS_RST[STAT_PIN_BIT];
    end else begin
      overflow_flag       <= next_ovf_flag;
      overflow_irq_enable <= next_ien;
      pin_irq_flag        <= next_pin_flag;
    end
  end

  // wave levels
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pwm_level    <= 1'b1;
      toggle_level <= 1'b0;
    end else begin
      pwm_level    <= next_pwm;
      toggle_level <= next_toggle;
    end
  end

  // registered outputs toward the system and the pin
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_WAVE_OUT     <= 1'b0;
      O_WAVE_OE      <= 1'b0;
      O_OVF_IRQ      <= 1'b0;
      O_IRQ_VECTOR   <= IRQ_VECTOR;
      O_PIN_IRQ_FLAG <= 1'b0;
      O_WAKEUP       <= 1'b0;
    end else begin
      O_WAVE_OUT     <= next_pin_out;
      O_WAVE_OE      <= next_pin_oe;
      O_OVF_IRQ      <= next_ovf_flag && next_ien;
      O_IRQ_VECTOR   <= IRQ_VECTOR;
      O_PIN_IRQ_FLAG <= next_pin_flag;
      O_WAKEUP       <= 1'b0;
    end
  end

  // bus answer: ack one cycle after the request, then one idle cycle
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= TMR_BUS_IDLE;
      O_WB_ACK  <= 1'b0;
      O_WB_DAT  <= 32'h0000_0000;
    end else begin
      case (bus_state)
        TMR_BUS_IDLE: begin
          O_WB_ACK <= wb_req;
          if (wb_req) begin
            bus_state <= TMR_BUS_ACK;
            O_WB_DAT  <= {24'h00_0000, rd_data};
          end
        end
        TMR_BUS_ACK: begin
          O_WB_ACK  <= 1'b0;
          bus_state <= TMR_BUS_IDLE;
        end
        default: begin
          O_WB_ACK  <= 1'b0;
          bus_state <= TMR_BUS_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [tmr_timer_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr_timer_chk
  import tmr_pkg::*;
(
  // clock, reset and bus
  input wire logic             I_CLK,
  input wire logic             I_RESET_N,
  input wire logic             I_WB_CYC,
  input wire logic             I_WB_STB,
  input wire logic             I_WB_WE,
  input wire logic [ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0]       I_WB_SEL,
  input wire logic [31:0]      I_WB_DAT,
  input wire logic             O_WB_ACK,
  // pins and system side
  input wire logic             I_GPIO_OUT,
  input wire logic             I_GPIO_OE,
  input wire logic             O_WAVE_OUT,
  input wire logic             O_WAVE_OE,
  input wire logic             O_OVF_IRQ,
  input wire logic [7:0]       O_IRQ_VECTOR,
  input wire logic             O_PIN_IRQ_FLAG,
  input wire logic             O_WAKEUP
);
  logic [1:0] up;
  logic [1:0] cks_age;
  logic [7:0] md;
  logic       ien;
  // write taken at this edge and its target
  wire        wr    = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK && I_WB_SEL[0];
  wire        md_wr = wr && I_WB_ADR[9:2] == IDX_MODE;
  wire        st_wr = wr && I_WB_ADR[9:2] == IDX_STATUS;

  // settle count after reset, shadows of mode and enable
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      up      <= 2'h0;
      cks_age <= 2'h0;
      md      <= 8'h00;
      ien     <= 1'b0;
    end else begin
      up      <= (up == 2'h3) ? up : up + 2'h1;
      cks_age <= !md[3] ? 2'h0 : (cks_age == 2'h3) ? cks_age : cks_age + 2'h1;
      md      <= md_wr ? I_WB_DAT[7:0] : md;
      ien     <= st_wr ? I_WB_DAT[1] : ien;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N || up != 2'h3);

  // bus answer, system side and shared pin outputs
  a_ack_follows_req: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property ($rose(O_WB_ACK) |=> $fell(O_WB_ACK))
    else $error("ack longer than one cycle");
  a_never_wakes: assert property (!O_WAKEUP)
    else $error("wakeup raised");
  a_vector_fixed: assert property (O_IRQ_VECTOR == 8'h08)
    else $error("wrong interrupt vector");
  a_irq_needs_enable: assert property (O_OVF_IRQ |-> ien)
    else $error("interrupt while disabled");
  a_flag_sticky: assert property ($fell(O_OVF_IRQ) |-> $past(st_wr))
    else $error("interrupt dropped without status write");
  a_hold_when_off: assert property (!md[7] && !$past(md[7]) && ien && $past(ien)
    |-> !$rose(O_OVF_IRQ))
    else $error("overflow while stopped");
  a_event_pin_quiet: assert property (cks_age == 2'h3 |-> !O_PIN_IRQ_FLAG)
    else $error("pin flag set in event mode");
  a_wave_driven: assert property ($past(md[0]) || $past(md[1]) |-> O_WAVE_OE)
    else $error("pin not driven by timer");
  a_gpio_passthru: assert property (!$past(md[0]) && !$past(md[1])
    |-> O_WAVE_OE == $past(I_GPIO_OE) && O_WAVE_OUT == $past(I_GPIO_OUT))
    else $error("pin not returned to gpio");

  // main scenarios reached
  c_write: cover property (md_wr);
  c_irq: cover property ($rose(O_OVF_IRQ));
  c_pwm: cover property (md[0] && md[7] && O_WAVE_OUT);
endmodule

bind tmr_timer tmr_timer_chk tmr_timer_chk_i (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .I_GPIO_OUT(I_GPIO_OUT), .I_GPIO_OE(I_GPIO_OE),
  .O_WAVE_OUT(O_WAVE_OUT), .O_WAVE_OE(O_WAVE_OE), .O_OVF_IRQ(O_OVF_IRQ),
  .O_IRQ_VECTOR(O_IRQ_VECTOR), .O_PIN_IRQ_FLAG(O_PIN_IRQ_FLAG), .O_WAKEUP(O_WAKEUP)
);
`default_nettype wire

// [tmr_far.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr_far (
  // shared pin drive from the block
  input  wire logic i_out,
  input  wire logic i_oe,
  // pin level and event source
  output logic      o_pin,
  output logic      o_event
);
  // released pin is pulled up
  assign o_pin = i_oe ? i_out : 1'b1;
  initial o_event = 1'b1;
  // n falling edges, each level held t ns, free of the clock
  task automatic pulses(input int n, input int t);
    repeat (n) begin
      #(t) o_event = 1'b0;
      #(t) o_event = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// [tb_tmr_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_tmr_timer
  import tmr_pkg::*;
  ;
  logic             clk   = 1'b0;
  logic             rst_n = 1'b0;
  logic             cyc   = 1'b0;
  logic             stb   = 1'b0;
  logic             we    = 1'b0;
  logic [ADR_W-1:0] adr   = {ADR_W{1'b0}};
  logic [3:0]       sel   = 4'hF;
  logic [31:0]      wdat  = 32'h0;
  logic             gout  = 1'b0;
  logic             goe   = 1'b0;
  logic [31:0]      rdat;
  logic [7:0]       vec;
  logic             ack, ev, wout, woe, irq, pflag, wake, pin;
  int               error_cnt = 0;
  int               check_count = 0;
  int               cycles = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  tmr_timer tmr_timer_i (.I_CLK(clk), .I_RESET_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_EVENT_PIN(ev), .I_GPIO_OUT(gout), .I_GPIO_OE(goe),
    .O_WAVE_OUT(wout), .O_WAVE_OE(woe), .O_OVF_IRQ(irq), .O_IRQ_VECTOR(vec),
    .O_PIN_IRQ_FLAG(pflag), .O_WAKEUP(wake));
  tmr_far tmr_far_i (.i_out(wout), .i_oe(woe), .o_pin(pin), .o_event(ev));

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask

  // one classic cycle, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n == 40) error_cnt++;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e, input string s);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(s, e, q);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic s_regs();
    rd(IDX_MODE, 8'h00, "mode reset");
    rd(IDX_COUNT, 8'h00, "count reset");
    wr(IDX_MODE, 8'h76);
    rd(IDX_MODE, 8'h76, "mode rw");
    wr(IDX_COUNT, 8'hA5);
    rd(IDX_COUNT, 8'hA5, "count rw");
    rd(IDX_RELOAD, 8'h00, "reload write only");
    wr(8'h11, 8'h5A);
    rd(8'h11, 8'h00, "unmapped");
    sel <= 4'h0;
    wr(IDX_COUNT, 8'h3C);
    sel <= 4'hF;
    rd(IDX_COUNT, 8'hA5, "lane off");
    wr(IDX_MODE, 8'h00);
  endtask

  // four ticks at every rate, then held while stopped
  task automatic s_rate();
    for (int c = 0; c < 8; c++) begin
      wr(IDX_COUNT, 8'h00);
      wr(IDX_MODE, {1'b1, c[2:0], 4'h0});
      repeat ((4 << (8 - c)) - 1) @(posedge clk);
      wr(IDX_MODE, 8'h00);
      repeat (4) @(posedge clk);
      rd(IDX_COUNT, 8'h04, "prescaled count");
    end
  endtask

  task automatic s_ovf();
    wr(IDX_STATUS, 8'h02);
    wr(IDX_COUNT, 8'hFD);
    wr(IDX_RELOAD, 8'hF0);
    wr(IDX_MODE, 8'h84);
    wait_irq();
    chk("overflow irq", 8'h01, {7'h0, irq});
    chk("vector", 8'h08, vec);
    rd(IDX_COUNT, 8'hF0, "reloaded");
    wr(IDX_STATUS, 8'h01);
    chk("masked irq", 8'h00, {7'h0, irq});
    rd(IDX_STATUS, 8'h01, "flag kept");
    wr(IDX_STATUS, 8'h02);
    rd(IDX_STATUS, 8'h02, "flag cleared");
    wr(IDX_MODE, 8'h80);
    wr(IDX_COUNT, 8'hFF);
    wait_irq();
    rd(IDX_COUNT, 8'h00, "no reload");
    wr(IDX_MODE, 8'h00);
    wr(IDX_STATUS, 8'h00);
  endtask

  // high time over one period for each resolution
  task automatic s_pwm();
    int n;
    int h;
    for (int r = 0; r < 4; r++) begin
      n = (r == 0) ? 256 : (64 >> (r - 1));
      wr(IDX_COUNT, 8'h00);
      wr(IDX_RELOAD, 8'(n / 4));
      wr(IDX_MODE, {1'b1, 3'h7, 1'b0, r[1:0], 1'b1});
      repeat (2 * n) @(posedge clk);
      h = 0;
      repeat (2 * n) begin
        @(posedge clk);
        h += pin;
      end
      chk("pwm high", 8'(n / 2), 8'(h));
    end
    wr(IDX_MODE, 8'h00);
  endtask

  task automatic s_tog();
    int h;
    wr(IDX_COUNT, 8'hF0);
    wr(IDX_RELOAD, 8'hF0);
    wr(IDX_MODE, 8'hF6);
    repeat (64) @(posedge clk);
    h = 0;
    repeat (64) begin
      @(posedge clk);
      h += pin;
    end
    chk("toggle high", 8'h20, 8'(h));
    wr(IDX_MODE, 8'h00);
    goe <= 1'b1;
    repeat (2) @(posedge clk);
    chk("gpio low", 8'h00, {7'h0, pin});
    goe <= 1'b0;
    gout <= 1'b1;
    repeat (2) @(posedge clk);
    chk("gpio released", 8'h00, {7'h0, woe});
  endtask

  task automatic s_evt();
    tmr_far_i.pulses(1, 23);
    repeat (4) @(posedge clk);
    chk("pin flag", 8'h01, {7'h0, pflag});
    wr(IDX_STATUS, 8'h00);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_MODE, 8'hF8);
    tmr_far_i.pulses(3, 23);
    tmr_far_i.pulses(2, 61);
    repeat (6) @(posedge clk);
    rd(IDX_COUNT, 8'h05, "events");
    chk("pin flag quiet", 8'h00, {7'h0, pflag});
    wr(IDX_MODE, 8'h00);
  endtask

  // cut a hung run short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    s_regs();
    s_rate();
    s_ovf();
    s_pwm();
    s_tog();
    s_evt();
    chk("wakeup", 8'h00, {7'h0, wake});
    conclude();
  end
endmodule
`default_nettype wire
